// *** hw/bdp_pkg.sv ***
// Contract
// - Normal target from normal set point field
// - Standby high selects standby set point outside Sleep
// - Sleep mode selects sleep set point
// - Software set point changes ramp on a buck that is on; an off buck follows at once
// - Standby and turn-off ramps use step rate
// - Buck1 25 mV steps, 2-16 us intervals
// - Buck2/3 bit6 set doubles interval, 50 mV
// - Mask overcurrent while output is stepping
// - Phase field picks 0/90/180/270 degrees
// - Phase resets 0, 90, 180 degrees
// - Frequency field picks 1/2/4 MHz, 11 reserved
// - Phase and frequency chosen independently
// - Stage field resets to all stages on
// - Stage field enables paralleled power stages
// - Current limit scales with enabled stages
// - Turn-off: keep-on bucks sleep, others off
package bdp_pkg;
	localparam int CLK_NS = 5;
	localparam int DVS_BASE_NS = 2000;
	localparam int DVS_BASE_CYC = (DVS_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int F1_NS = 1000;
	localparam int F2_NS = 500;
	localparam int F4_NS = 250;
	localparam logic [7:0] P1_CYC = 8'(F1_NS / CLK_NS);
	localparam logic [7:0] P2_CYC = 8'(F2_NS / CLK_NS);
	localparam logic [7:0] P4_CYC = 8'(F4_NS / CLK_NS);
	localparam int NB = 3;
	localparam int NS = 4;
	localparam logic BTN_IDLE = 1'b1;
	localparam logic [2:0] OFF_NORM = 3'h0;
	localparam logic [2:0] OFF_STBY = 3'h1;
	localparam logic [2:0] OFF_SLEEP = 3'h2;
	localparam logic [2:0] OFF_CONF = 3'h3;
	localparam logic [2:0] OFF_STG = 3'h4;
	localparam logic [2:0] OFF_STGB = 3'h5;
	localparam logic [2:0] OFF_LIVE = 3'h6;
	localparam logic [1:0] BLK_STATUS = 2'h3;
	localparam logic [6:0] SP_MASK1 = 7'h3f;
	localparam logic [6:0] SP_MASK = 7'h7f;
	localparam logic [6:0] SP_NORM_RST = 7'h20;
	localparam logic [6:0] SP_STBY_RST = 7'h18;
	localparam logic [6:0] SP_SLEEP_RST = 7'h10;
	localparam logic [1:0] RATE_RST = 2'h1;
	localparam logic [1:0] FREQ_RST = 2'h1;
	localparam logic [1:0] PH_0 = 2'h0;
	localparam logic [1:0] PH_90 = 2'h1;
	localparam logic [1:0] PH_180 = 2'h2;
	localparam logic [2:0] STG_1 = 3'h1;
	localparam logic [2:0] STG_3 = 3'h3;
	localparam logic [2:0] STG_5 = 3'h5;
	localparam logic [2:0] STG_ALL = 3'h7;
	localparam logic [6:0] PCT_1 = 7'h28;
	localparam logic [6:0] PCT_3 = 7'h50;
	localparam logic [6:0] PCT_5 = 7'h3c;
	localparam logic [6:0] PCT2_1 = 7'h26;
	localparam logic [6:0] PCT2_3 = 7'h4b;
	localparam logic [6:0] PCT2_5 = 7'h3f;
	localparam logic [6:0] PCT_ALL = 7'h64;
	typedef enum logic [0:0] {ST_NORMAL = 1'h0, ST_SLEEP = 1'h1} bdp_state_t;
	typedef enum logic [1:0] {FQ_1M = 2'h0, FQ_2M = 2'h1, FQ_4M = 2'h2, FQ_RSV = 2'h3} bdp_freq_t;
	// Percent of stages on; buck2 has its own split
	function automatic logic [6:0] bdp_pct(input logic [2:0] code, input logic narrow);
		logic [6:0] p;
		p = 7'h00;
		case (code)
			STG_1: p = narrow ? PCT2_1 : PCT_1;
			STG_3: p = narrow ? PCT2_3 : PCT_3;
			STG_5: p = narrow ? PCT2_5 : PCT_5;
			STG_ALL: p = PCT_ALL;
			default: p = 7'h00;
		endcase
		return p;
	endfunction
endpackage

// *** hw/bdp_step_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bdp_step_if;
	logic [6:0] target;
	logic [6:0] setpoint;
	logic [1:0] rate;
	logic coarse;
	logic hold;
	logic busy;
	modport ctrl(output target, output rate, output coarse, output hold,
		input setpoint, input busy);
	modport step(input target, input rate, input coarse, input hold,
		output setpoint, output busy);
endinterface
`default_nettype wire

// *** hw/bdp_stepper.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdp_stepper #(
	parameter int BASE_CYC = bdp_pkg::DVS_BASE_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Control side
	bdp_step_if.step s
);
	import bdp_pkg::*;
	logic [15:0] cnt_q;
	logic [6:0] sp_q;
	logic [6:0] tgt_q;
	logic [15:0] lim;
	logic fire;
	// Coarse range doubles the interval
	assign lim = 16'(BASE_CYC) << ({1'b0, s.rate} + {2'h0, s.coarse});
	assign fire = (cnt_q == lim - 16'h0001) && (s.target == tgt_q);
	assign s.setpoint = sp_q;
	assign s.busy = (sp_q != s.target);
	// Track target so a mid-ramp change restarts the interval
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tgt_q <= SP_NORM_RST;
		end else begin
			tgt_q <= s.target;
		end
	end
	// Interval counter
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_q <= 16'h0000;
		end else if (s.hold || !s.busy || s.target != tgt_q || fire) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// One code per interval; an off regulator just follows
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sp_q <= SP_NORM_RST;
		end else if (s.hold) begin
			sp_q <= s.target;
		end else if (fire && sp_q < s.target) begin
			sp_q <= sp_q + 7'h01;
		end else if (fire && sp_q > s.target) begin
			sp_q <= sp_q - 7'h01;
		end
	end
	chk_step_unit: assert property (@(posedge clk_in) disable iff (reset_in)
		!$past(s.hold) && $changed(sp_q) |-> (sp_q == $past(sp_q) + 7'h01
		&& $past(s.target) > $past(sp_q)) || (sp_q == $past(sp_q) - 7'h01
		&& $past(s.target) < $past(sp_q)))
		else $error("setpoint stepped wrong way or size");
	chk_step_wait: assert property (@(posedge clk_in) disable iff (reset_in)
		!s.hold && s.busy && cnt_q == 16'h0000 && s.target == tgt_q
		&& $stable(s.target) |=> $stable(sp_q))
		else $error("setpoint stepped without waiting an interval");
	cov_ramp: cover property (@(posedge clk_in) disable iff (reset_in)
		$rose(s.busy) ##[1:1000] $fell(s.busy));
endmodule
`default_nettype wire

// *** hw/bdp_phase_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module bdp_phase_gen (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Settings
	input wire logic [1:0] phase_in,
	input wire logic [1:0] freq_in,
	// Switching clock
	output logic clk_out
);
	import bdp_pkg::*;
	logic [7:0] cnt_q;
	logic [7:0] per;
	logic [7:0] off;
	logic [7:0] sh;
	// Period from frequency alone, offset is phase times a quarter of that period
	always_comb begin
		unique case (freq_in)
			FQ_1M: per = P1_CYC;
			FQ_2M: per = P2_CYC;
			FQ_4M: per = P4_CYC;
			FQ_RSV: per = P1_CYC;
		endcase
	end
	assign off = 8'((per >> 2) * {6'h00, phase_in});
	assign sh = (cnt_q >= off) ? cnt_q - off : 8'(cnt_q + per - off);
	// Free-running period counter; >= covers a shrinking period
	always_ff @(posedge clk_in) begin
		if (reset_in || cnt_q >= per - 8'h01) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	// Reserved code parks the clock low
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= (freq_in != FQ_RSV) && (sh < (per >> 1));
		end
	end
	chk_rsv_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
		freq_in == FQ_RSV |=> !clk_out)
		else $error("reserved frequency code toggled clock");
	chk_phase_edge: assert property (@(posedge clk_in) disable iff (reset_in)
		freq_in != FQ_RSV && cnt_q == off |=> clk_out)
		else $error("clock not high at phase offset");
endmodule
`default_nettype wire

// *** hw/bdp_top.sv ***
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bdp_top #(
	parameter int DVS_BASE_CYCLES = bdp_pkg::DVS_BASE_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [4:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Pins from the processor and analog side
	input wire logic standby_in,
	input wire logic power_button_input_in,
	input wire logic [bdp_pkg::NB-1:0] ocp_in,
	// Regulator controls
	output logic [bdp_pkg::NB-1:0][6:0] setpoint_out,
	output logic [bdp_pkg::NB-1:0] reg_on_out,
	output logic sleep_mode_out,
	output logic [bdp_pkg::NB-1:0] ocp_fault_out,
	output logic [bdp_pkg::NB-1:0] sw_clk_out,
	// Power stages: buck1, buck2, buck3a, buck3b
	output logic [bdp_pkg::NS-1:0][2:0] stage_en_out,
	output logic [bdp_pkg::NS-1:0][6:0] ilim_pct_out
);
	import bdp_pkg::*;

	// Synchroniser stages for pins
	logic [NB+1:0] meta_q;
	logic [NB+1:0] sync_q;
	logic stby_s;
	logic btn_s;
	logic [NB-1:0] ocp_s;
	logic btn_prev_q;
	logic off_ev;
	logic on_ev;

	// Mode state
	bdp_state_t st_q;
	logic [NB-1:0] reg_on_q;

	// Software fields
	logic [6:0] norm_q [NB];
	logic [6:0] stby_q [NB];
	logic [6:0] sleep_q [NB];
	logic [1:0] rate_q [NB];
	logic [1:0] phase_q [NB];
	logic [1:0] freq_q [NB];
	logic [NB-1:0] keep_q;
	logic [2:0] stage_q [NS];

	// Per-regulator derived values
	logic [6:0] tgt [NB];
	logic [6:0] live [NB];
	logic [NB-1:0] busy;
	logic [NB-1:0] fault_q;
	logic [6:0] ilim_q [NS];
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [1:0] blk;
	logic [2:0] off;

	assign blk = addr_in[4:3];
	assign off = addr_in[2:0];

	// Two flops per pin before any logic looks at it
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			// Button bit starts released, so leaving reset is not a turn-off
			meta_q <= {{NB{1'b0}}, BTN_IDLE, 1'b0};
			sync_q <= {{NB{1'b0}}, BTN_IDLE, 1'b0};
		end else begin
			meta_q <= {ocp_in, power_button_input_in, standby_in};
			sync_q <= meta_q;
		end
	end

	assign stby_s = sync_q[0];
	assign btn_s = sync_q[1];
	assign ocp_s = sync_q[NB+1:2];

	// Button edge detect on the synchronised level
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			btn_prev_q <= BTN_IDLE;
		end else begin
			btn_prev_q <= btn_s;
		end
	end

	// Falling level is a turn-off request, rising is turn-on
	assign off_ev = btn_prev_q && !btn_s;
	assign on_ev = !btn_prev_q && btn_s;

	// Normal / Sleep mode
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= ST_NORMAL;
		end else begin
			unique case (st_q)
				ST_NORMAL: begin
					if (off_ev) begin
						st_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (on_ev) begin
						st_q <= ST_NORMAL;
					end
				end
			endcase
		end
	end

	// Keep-on regulators stay up in Sleep, the rest shut down
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			reg_on_q <= '1;
		end else if (st_q == ST_NORMAL && off_ev) begin
			reg_on_q <= keep_q;
		end else if (st_q == ST_SLEEP && on_ev) begin
			reg_on_q <= '1;
		end
	end

	// Set point fields; a powered-up regulator returns to its default
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < NB; i++) begin
				norm_q[i] <= SP_NORM_RST;
				stby_q[i] <= SP_STBY_RST;
				sleep_q[i] <= SP_SLEEP_RST;
			end
		end else begin
			for (int i = 0; i < NB; i++) begin
				if (st_q == ST_SLEEP && on_ev && !reg_on_q[i]) begin
					norm_q[i] <= SP_NORM_RST;
				end else if (wr_in && blk == 2'(i) && off == OFF_NORM) begin
					norm_q[i] <= wdata_in[6:0] & (i == 0 ? SP_MASK1 : SP_MASK);
				end
				if (wr_in && blk == 2'(i) && off == OFF_STBY) begin
					stby_q[i] <= wdata_in[6:0] & (i == 0 ? SP_MASK1 : SP_MASK);
				end
				if (wr_in && blk == 2'(i) && off == OFF_SLEEP) begin
					sleep_q[i] <= wdata_in[6:0] & (i == 0 ? SP_MASK1 : SP_MASK);
				end
			end
		end
	end

	// Config fields: rate [1:0], phase [3:2], freq [5:4], keep-on [6]
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < NB; i++) begin
				rate_q[i] <= RATE_RST;
				freq_q[i] <= FREQ_RST;
			end
			phase_q[0] <= PH_0;
			phase_q[1] <= PH_90;
			phase_q[2] <= PH_180;
			keep_q <= '1;
		end else begin
			for (int i = 0; i < NB; i++) begin
				if (wr_in && blk == 2'(i) && off == OFF_CONF) begin
					rate_q[i] <= wdata_in[1:0];
					phase_q[i] <= wdata_in[3:2];
					freq_q[i] <= wdata_in[5:4];
					keep_q[i] <= wdata_in[6];
				end
			end
		end
	end

	// Stage fields; bit0 is not forced, software keeps it set
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int j = 0; j < NS; j++) begin
				stage_q[j] <= STG_ALL;
			end
		end else begin
			for (int i = 0; i < NB; i++) begin
				if (wr_in && blk == 2'(i) && off == OFF_STG) begin
					stage_q[i] <= wdata_in[2:0];
				end
			end
			if (wr_in && blk == 2'(NB - 1) && off == OFF_STGB) begin
				stage_q[NS-1] <= wdata_in[2:0];
			end
		end
	end

	// Current limit follows the stage fraction
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int j = 0; j < NS; j++) begin
				ilim_q[j] <= PCT_ALL;
			end
		end else begin
			for (int j = 0; j < NS; j++) begin
				ilim_q[j] <= bdp_pct(stage_q[j], j == 1);
			end
		end
	end

	// Target priority: Sleep, then standby, then normal
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			if (st_q == ST_SLEEP) begin
				tgt[i] = sleep_q[i];
			end else if (stby_s) begin
				tgt[i] = stby_q[i];
			end else begin
				tgt[i] = norm_q[i];
			end
		end
	end

	// Per-regulator stepper and switching clock
	for (genvar g = 0; g < NB; g++) begin : g_buck
		bdp_step_if u_if();
		assign u_if.target = tgt[g];
		assign u_if.rate = rate_q[g];
		assign u_if.coarse = (g != 0) && tgt[g][6];
		assign u_if.hold = !reg_on_q[g];
		assign live[g] = u_if.setpoint;
		assign busy[g] = u_if.busy;

		bdp_stepper #(
			.BASE_CYC(DVS_BASE_CYCLES)
		) u_step (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.s(u_if)
		);

		bdp_phase_gen u_ph (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.phase_in(phase_q[g]),
			.freq_in(freq_q[g]),
			.clk_out(sw_clk_out[g])
		);
	end

	// Overcurrent hidden while ramping, so a ramp never trips a fault
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_q <= '0;
		end else begin
			fault_q <= ocp_s & ~busy & reg_on_q;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (blk == BLK_STATUS) begin
			if (off == 3'h0) begin
				rdata_d = {stby_s, st_q, reg_on_q, busy};
			end
		end else begin
			unique case (off)
				OFF_NORM: rdata_d = {1'b0, norm_q[blk]};
				OFF_STBY: rdata_d = {1'b0, stby_q[blk]};
				OFF_SLEEP: rdata_d = {1'b0, sleep_q[blk]};
				OFF_CONF: rdata_d = {1'b0, keep_q[blk], freq_q[blk],
					phase_q[blk], rate_q[blk]};
				OFF_STG: rdata_d = {5'h00, stage_q[blk]};
				OFF_STGB: rdata_d = (blk == 2'(NB - 1)) ? {5'h00, stage_q[NS-1]} : 8'h00;
				OFF_LIVE: rdata_d = {1'b0, live[blk]};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge clk_in) begin
		if (reset_in || !rd_in) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Output wiring, all from flops
	assign rdata_out = rdata_q;
	assign reg_on_out = reg_on_q;
	assign sleep_mode_out = (st_q == ST_SLEEP);
	assign ocp_fault_out = fault_q;
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			setpoint_out[i] = live[i];
		end
		for (int j = 0; j < NS; j++) begin
			stage_en_out[j] = stage_q[j];
			ilim_pct_out[j] = ilim_q[j];
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	chk_normal_target: assert property (
		st_q == ST_NORMAL && !stby_s |-> tgt[1] == norm_q[1])
		else $error("normal target not from normal field");
	chk_standby_target: assert property (
		st_q == ST_NORMAL && stby_s |-> tgt[0] == stby_q[0])
		else $error("standby target not from standby field");
	chk_sleep_target: assert property (
		st_q == ST_SLEEP |-> tgt[2] == sleep_q[2])
		else $error("sleep target not from sleep field");
	chk_ocp_mask: assert property (
		busy[0] |=> !ocp_fault_out[0])
		else $error("overcurrent reported during ramp");
	chk_phase_reset: assert property (
		$past(reset_in) |-> phase_q[0] == PH_0 && phase_q[1] == PH_90
		&& phase_q[2] == PH_180)
		else $error("phase fields wrong after reset");
	chk_stage_reset: assert property (
		$past(reset_in) |-> stage_en_out[2] == STG_ALL && ilim_pct_out[2] == PCT_ALL)
		else $error("stage field wrong after reset");
	chk_ilim_scale: assert property (
		$stable(stage_q[1]) |-> ilim_pct_out[1] == bdp_pct(stage_q[1], 1'b1))
		else $error("current limit not scaled by stages");
	chk_sleep_off: assert property (
		st_q == ST_NORMAL && off_ev |=> st_q == ST_SLEEP
		&& reg_on_out == $past(keep_q))
		else $error("turn-off did not apply keep-on bits");
	cov_standby: cover property ($rose(stby_s) ##1 busy[0]);
	cov_sleep: cover property (st_q == ST_NORMAL && off_ev);
	cov_wake: cover property (st_q == ST_SLEEP && on_ev);
endmodule
`default_nettype wire

// *** verification/bdp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Processor side: register master plus standby and button pins
module bdp_host_model (
	// Clock
	input wire logic clk_in,
	// Register master
	output logic [4:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	input wire logic [7:0] rdata_in,
	// Mode pins
	output logic standby_out,
	output logic button_out
);
	// Idle bus; button starts released so no turn-off is seen at start
	initial begin
		addr_out = 5'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		standby_out = 1'b0;
		button_out = 1'b1;
	end
	// One-cycle write; data scrambled after so stale values are never trusted
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
	// Stage writes always keep the sensing stage on
	task automatic wr_stage(input logic [4:0] a, input logic [2:0] c);
		wr(a, {5'h00, c | 3'h1});
	endtask
	// Mode pins change just after an edge
	task automatic pins(input logic s, input logic b);
		@(posedge clk_in);
		standby_out <= s;
		button_out <= b;
	endtask
endmodule
`default_nettype wire

// *** verification/buck_dvs_phase_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module buck_dvs_phase_control_test;
	import bdp_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic standby;
	logic button;
	logic [NB-1:0] ocp = 3'h0;
	logic [NB-1:0][6:0] sp;
	logic [NB-1:0] reg_on;
	logic sleep;
	logic [NB-1:0] fault;
	logic [NB-1:0] sw_clk;
	logic [NS-1:0][2:0] stage;
	logic [NS-1:0][6:0] ilim;
	logic [6:0] c = 7'h20;
	int fail_count = 0;
	int n_checks = 0;
	// Short base interval keeps every ramp brief
	bdp_top #(.DVS_BASE_CYCLES(4)) u_bdp_top (.clk_in(clk_in), .reset_in(reset_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.standby_in(standby), .power_button_input_in(button), .ocp_in(ocp),
		.setpoint_out(sp), .reg_on_out(reg_on), .sleep_mode_out(sleep),
		.ocp_fault_out(fault), .sw_clk_out(sw_clk), .stage_en_out(stage),
		.ilim_pct_out(ilim));
	bdp_host_model u_bdp_host_model (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd), .rdata_in(rdata), .standby_out(standby),
		.button_out(button));
	// 200 MHz clock
	always #2.5 clk_in = ~clk_in;
	// Compare of design values, four-state exact
	task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Compare of measured cycle counts
	task automatic chk_n(input string nm, input int e, input int g);
		n_checks++;
		if (g != e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic end_sim();
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Sample just after an edge so updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_bdp_host_model.rd(a, d);
		chk_v(nm, e, d);
	endtask
	// Cycles until the next set point change, and the value it lands on
	task automatic next_step(input int b, input logic [6:0] e, output int n);
		logic [6:0] v;
		v = sp[b];
		n = 0;
		while (sp[b] === v && n < 2000) begin
			settle(1);
			n++;
		end
		chk_v("setpoint", {1'b0, e}, {1'b0, sp[b]});
	endtask
	task automatic wait_sp(input int b, input logic [6:0] e);
		for (int i = 0; i < 3000 && sp[b] !== e; i++) settle(1);
		chk_v("final setpoint", {1'b0, e}, {1'b0, sp[b]});
	endtask
	// Cycles until the next rising edge of a switching clock
	task automatic rise(input int b, output int n);
		logic p;
		p = sw_clk[b];
		n = 0;
		while (!(sw_clk[b] === 1'b1 && p === 1'b0) && n < 1000) begin
			p = sw_clk[b];
			settle(1);
			n++;
		end
	endtask
	task automatic t_reset();
		int n;
		rdchk("conf1", 5'h03, 8'h51);
		rdchk("conf2", 5'h0b, 8'h55);
		rdchk("conf3", 5'h13, 8'h59);
		rdchk("stage3b", 5'h15, 8'h07);
		chk_v("stage2", 8'h07, {5'h00, stage[1]});
		chk_v("ilim3b", 8'h64, {1'b0, ilim[3]});
		rdchk("unmapped", 5'h07, 8'h00);
		rise(0, n);
		rise(1, n);
		chk_n("lag2", 25, n % 100);
		rise(0, n);
		rise(2, n);
		chk_n("lag3", 50, n % 100);
	endtask
	task automatic t_phase();
		int n;
		for (int p = 0; p < 4; p++) begin
			u_bdp_host_model.wr(5'h0b, 8'h51 | 8'(p << 2));
			settle(300);
			rise(0, n);
			rise(1, n);
			chk_n("phase lag", 25 * p, n % 100);
		end
		// Phase 180 against buck1 at 2 MHz is the recommended pairing
		for (int f = 0; f < 3; f++) begin
			u_bdp_host_model.wr(5'h0b, 8'h49 | 8'(f << 4));
			settle(500);
			rise(1, n);
			rise(1, n);
			chk_n("period", 200 >> f, n);
		end
		// Reserved code must park the clock; rise() runs to its limit
		u_bdp_host_model.wr(5'h0b, 8'h79);
		settle(2);
		rise(1, n);
		chk_n("reserved quiet", 1000, n);
		u_bdp_host_model.wr(5'h0b, 8'h55);
	endtask
	task automatic t_ramp();
		int n;
		for (int r = 0; r < 4; r++) begin
			u_bdp_host_model.wr(5'h03, 8'h50 | 8'(r));
			u_bdp_host_model.wr(5'h00, {1'b0, c + 7'h02});
			next_step(0, c + 7'h01, n);
			next_step(0, c + 7'h02, n);
			chk_n("step gap", 4 << r, n);
			c = c + 7'h02;
		end
		u_bdp_host_model.wr(5'h00, {1'b0, c - 7'h01});
		next_step(0, c - 7'h01, n);
		c = c - 7'h01;
		settle(70);
		chk_v("no overshoot", {1'b0, c}, {1'b0, sp[0]});
		rdchk("live", 5'h06, {1'b0, c});
	endtask
	task automatic t_coarse();
		int n;
		u_bdp_host_model.wr(5'h08, 8'h22);
		next_step(1, 7'h21, n);
		next_step(1, 7'h22, n);
		chk_n("fine gap", 8, n);
		u_bdp_host_model.wr(5'h08, 8'h62);
		next_step(1, 7'h23, n);
		next_step(1, 7'h24, n);
		chk_n("coarse gap", 16, n);
		u_bdp_host_model.wr(5'h08, 8'h20);
		wait_sp(1, 7'h20);
	endtask
	task automatic t_standby();
		int n;
		@(posedge clk_in);
		ocp <= 3'h1;
		u_bdp_host_model.wr(5'h03, 8'h50);
		settle(6);
		chk_v("fault idle", 8'h01, {5'h00, fault});
		u_bdp_host_model.pins(1'b1, 1'b1);
		next_step(0, c - 7'h01, n);
		chk_v("fault ramp", 8'h00, {5'h00, fault});
		next_step(0, c - 7'h02, n);
		chk_n("standby gap", 4, n);
		wait_sp(0, 7'h18);
		wait_sp(1, 7'h18);
		wait_sp(2, 7'h18);
		settle(6);
		rdchk("status", 5'h18, 8'hb8);
		chk_v("fault done", 8'h01, {5'h00, fault});
		@(posedge clk_in);
		ocp <= 3'h0;
		u_bdp_host_model.pins(1'b0, 1'b1);
		wait_sp(0, c);
	endtask
	task automatic t_sleep();
		u_bdp_host_model.wr(5'h13, 8'h19);
		u_bdp_host_model.pins(1'b0, 1'b0);
		wait_sp(0, 7'h10);
		wait_sp(1, 7'h10);
		chk_v("sleep", 8'h01, {7'h00, sleep});
		chk_v("reg on", 8'h03, {5'h00, reg_on});
		u_bdp_host_model.pins(1'b0, 1'b1);
		wait_sp(0, c);
		chk_v("awake", 8'h00, {7'h00, sleep});
		chk_v("reg on wake", 8'h07, {5'h00, reg_on});
	endtask
	task automatic t_stage();
		logic [6:0] pw [4] = '{7'h28, 7'h50, 7'h3c, 7'h64};
		logic [6:0] p2 [4] = '{7'h26, 7'h4b, 7'h3f, 7'h64};
		for (int ch = 0; ch < 4; ch++) begin
			for (int k = 0; k < 4; k++) begin
				u_bdp_host_model.wr_stage(ch == 3 ? 5'h15 : 5'(ch * 8 + 4), 3'(2 * k + 1));
				settle(3);
				chk_v("stage", 8'(2 * k + 1), {5'h00, stage[ch]});
				chk_v("ilim", {1'b0, ch == 1 ? p2[k] : pw[k]}, {1'b0, ilim[ch]});
			end
		end
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		settle(1);
		chk_v("rdata idle", 8'h00, rdata);
		t_reset();
		t_phase();
		t_ramp();
		t_coarse();
		t_standby();
		t_sleep();
		t_stage();
		end_sim();
	end
	// Watchdog: the sequence needs under a fifth of this span
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end
endmodule
`default_nettype wire
